// ---- core/pss_port_status.sv ----
// Operation
// - Timeout query returns bits, clears those returned
// - Timeout enable mask, word or bit writable
// - Overflow query returns bits, clears those returned
// - Overflow enable mask, word or bit writable
// - Flow read clears bits except summary bit
// - Flow enable mask, word or bit writable
// - Clear-to-send level view is live, unlatched
// - Module port unconnected line reads zero
// - Serial port unconnected line reads one
// - Clear-to-send event query clears returned bits
// - Clear-to-send enable mask, word or bit writable
// - Data pending query clears returned bits
// - Data pending enable mask, word or bit writable
// - Optional port selector returns single bit
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module pss_port_status
  import pss_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [DW-1:0] pwdata,
  output logic      [DW-1:0] prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [PW-1:0] timeoutEvt,
  input  wire logic [PW-1:0] overflowEvt,
  input  wire logic [PW-1:0] flowEvt,
  input  wire logic [PW-1:0] pendingEvt,
  input  wire logic [PW-1:0] ctsPin,
  input  wire logic [PW-1:0] ctsPinDriven,
  output logic               irq
);

  pss_state_t             st_ff;
  pss_state_t             nxt_st;
  logic [NEV-1:0][PW-1:0] setArr;
  logic [NEV-1:0][PW-1:0] clrArr;
  logic [NEV-1:0][PW-1:0] evtArr;
  logic [NEV-1:0]         sumFlag;
  logic [PW-1:0]          ctsPinSync;
  logic [PW-1:0]          ctsDrvSync;
  logic [PW-1:0]          ctsLevel;
  logic [PW-1:0]          ctsChange;
  logic [PW-1:0]          selOneHot;
  logic [DW-1:0]          rdFull;
  logic [NEV-1:0]         evtHit;
  logic [NEV-1:0]         enHit;
  logic                   lvlHit;
  logic                   selHit;
  logic                   irqStHit;
  logic                   irqMaskHit;
  logic                   addrHit;
  logic                   accPhase;
  logic                   xferDone;
  logic                   selOk;

  // Pin level and drive state are synchronised before any logic reads them
  pss_sync #(
    .RST_VAL (CTS_PULL)
  ) u_cts_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (ctsPin),
    .dout  (ctsPinSync)
  );

  pss_sync #(
    .RST_VAL ('0)
  ) u_drv_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (ctsPinDriven),
    .dout  (ctsDrvSync)
  );

  // Undriven lines settle to the board pull level
  assign ctsLevel = (ctsPinSync & ctsDrvSync) | (CTS_PULL & ~ctsDrvSync);

  assign ctsChange = (ctsLevel ^ st_ff.ctsPrev) & PORT_MASK;

  assign setArr[EV_TMO]  = timeoutEvt;
  assign setArr[EV_OVF]  = overflowEvt;
  assign setArr[EV_FLOW] = flowEvt;
  assign setArr[EV_CTS]  = ctsChange;
  assign setArr[EV_PEND] = pendingEvt;

  assign accPhase = psel & penable;
  assign xferDone = accPhase & st_ff.ready;
  assign selOk    = st_ff.selValid && (st_ff.selPort >= MIN_PORT) &&
                    (st_ff.selPort <= MAX_PORT);
  assign selOneHot = PORT_ONE << st_ff.selPort;

  genvar gk;
  generate
    for (gk = 0; gk < NEV; gk++)
    begin : g_evt
      // Only bits captured at read time are cleared on completion
      assign clrArr[gk] = (xferDone && !pwrite && st_ff.clrSel[gk]) ?
                          st_ff.clrBits : '0;
      assign sumFlag[gk] = |(evtArr[gk] & st_ff.en[gk]);

      pss_evt_reg u_evt (
        .clk     (clk),
        .rst_n   (rst_n),
        .setBits (setArr[gk] & PORT_MASK),
        .clrBits (clrArr[gk]),
        .evtBits (evtArr[gk])
      );
    end
  endgenerate

  // Address decode
  always_comb
  begin
    evtHit     = '0;
    enHit      = '0;
    lvlHit     = 1'b0;
    selHit     = 1'b0;
    irqStHit   = 1'b0;
    irqMaskHit = 1'b0;
    addrHit    = 1'b1;
    if (paddr == A_TMO_EVT)
      evtHit[EV_TMO] = 1'b1;
    else if (paddr == A_TMO_EN)
      enHit[EV_TMO] = 1'b1;
    else if (paddr == A_OVF_EVT)
      evtHit[EV_OVF] = 1'b1;
    else if (paddr == A_OVF_EN)
      enHit[EV_OVF] = 1'b1;
    else if (paddr == A_FLOW_EVT)
      evtHit[EV_FLOW] = 1'b1;
    else if (paddr == A_FLOW_EN)
      enHit[EV_FLOW] = 1'b1;
    else if (paddr == A_CTS_EVT)
      evtHit[EV_CTS] = 1'b1;
    else if (paddr == A_CTS_EN)
      enHit[EV_CTS] = 1'b1;
    else if (paddr == A_PEND_EVT)
      evtHit[EV_PEND] = 1'b1;
    else if (paddr == A_PEND_EN)
      enHit[EV_PEND] = 1'b1;
    else if (paddr == A_CTS_LVL)
      lvlHit = 1'b1;
    else if (paddr == A_PORT_SEL)
      selHit = 1'b1;
    else if (paddr == A_IRQ_ST)
      irqStHit = 1'b1;
    else if (paddr == A_IRQ_MASK)
      irqMaskHit = 1'b1;
    else
      addrHit = 1'b0;
  end

  // Full-word read value
  always_comb
  begin
    rdFull = '0;
    for (int k = 0; k < NEV; k++)
    begin
      if (evtHit[k])
        rdFull[PW-1:0] = evtArr[k];
      if (enHit[k])
        rdFull[PW-1:0] = st_ff.en[k];
    end
    if (evtHit[EV_FLOW])
      rdFull[SUM_BIT] = sumFlag[EV_CTS];
    if (lvlHit)
      rdFull[PW-1:0] = ctsLevel;
    if (selHit)
      rdFull[SEL_VALID_BIT:0] = {st_ff.selValid, st_ff.selPort};
    if (irqStHit)
      rdFull[NEV-1:0] = st_ff.irqSt;
    if (irqMaskHit)
      rdFull[NEV-1:0] = st_ff.irqMask;
  end

  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.ready = accPhase & ~st_ff.ready;
    // Capture read data and the bits to clear one cycle before completion
    if (accPhase && !st_ff.ready)
    begin
      nxt_st.slverr  = ~addrHit;
      nxt_st.clrSel  = '0;
      nxt_st.clrBits = '0;
      nxt_st.rdata   = '0;
      if (!pwrite)
      begin
        nxt_st.clrSel = evtHit;
        if (selOk && (|evtHit || |enHit || lvlHit))
        begin
          nxt_st.rdata[0] = rdFull[st_ff.selPort];
          nxt_st.clrBits  = selOneHot & rdFull[PW-1:0];
        end
        else
        begin
          nxt_st.rdata   = rdFull;
          nxt_st.clrBits = rdFull[PW-1:0] & PORT_MASK;
        end
      end
    end
    if (xferDone && pwrite && addrHit)
    begin
      for (int k = 0; k < NEV; k++)
      begin
        if (enHit[k] && st_ff.selValid)
        begin
          if (selOk)
            nxt_st.en[k][st_ff.selPort] = pwdata[0];
        end
        else if (enHit[k])
          nxt_st.en[k] = pwdata[PW-1:0] & PORT_MASK;
      end
      if (selHit)
      begin
        nxt_st.selValid = pwdata[SEL_VALID_BIT];
        nxt_st.selPort  = pwdata[SEL_PORT_W-1:0];
      end
      if (irqStHit)
        nxt_st.irqSt = st_ff.irqSt & ~pwdata[NEV-1:0];
      if (irqMaskHit)
        nxt_st.irqMask = pwdata[NEV-1:0];
    end
    // Rising summary sets the sticky status after any clear
    nxt_st.irqSt   = nxt_st.irqSt | (sumFlag & ~st_ff.sumPrev);
    nxt_st.sumPrev = sumFlag;
    nxt_st.ctsPrev = ctsLevel;
    nxt_st.irq     = |(nxt_st.irqSt & nxt_st.irqMask);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff         <= '0;
      st_ff.ctsPrev <= CTS_PULL;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign prdata  = st_ff.rdata;
  assign pready  = st_ff.ready;
  assign pslverr = st_ff.slverr;
  assign irq     = st_ff.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_tmo_rdclr: assert property (
    xferDone && !pwrite && evtHit[EV_TMO]
    |=> (evtArr[EV_TMO] & $past(st_ff.clrBits) & ~$past(setArr[EV_TMO])) == '0)
    else $error("timeout bits not cleared by read");

  a_tmo_en_word: assert property (
    xferDone && pwrite && enHit[EV_TMO] && !st_ff.selValid
    |=> st_ff.en[EV_TMO] == ($past(pwdata[PW-1:0]) & PORT_MASK))
    else $error("timeout enable word write lost");

  a_ovf_rdclr: assert property (
    xferDone && !pwrite && evtHit[EV_OVF]
    |=> (evtArr[EV_OVF] & $past(st_ff.clrBits) & ~$past(setArr[EV_OVF])) == '0)
    else $error("overflow bits not cleared by read");

  a_ovf_en_bit: assert property (
    xferDone && pwrite && enHit[EV_OVF] && selOk
    |=> st_ff.en[EV_OVF][$past(st_ff.selPort)] == $past(pwdata[0]))
    else $error("overflow enable bit write lost");

  a_flow_summary: assert property (
    accPhase && !st_ff.ready && !pwrite && evtHit[EV_FLOW] && !selOk
    |=> prdata[SUM_BIT] == $past(sumFlag[EV_CTS]) && !st_ff.clrBits[0])
    else $error("flow read summary bit wrong");

  a_cts_live: assert property (
    accPhase && !st_ff.ready && !pwrite && lvlHit && !selOk
    |=> prdata[PW-1:0] == $past(ctsLevel))
    else $error("level read not live");

  a_cts_pull: assert property (
    (ctsPinDriven == '0) [*3] |-> ctsLevel == CTS_PULL)
    else $error("undriven line not at pull level");

  a_sel_onebit: assert property (
    accPhase && !st_ff.ready && !pwrite && selOk && (|evtHit || |enHit || lvlHit)
    |=> prdata[DW-1:1] == '0 ##1 !pready)
    else $error("selected read wider than one bit");

  a_pend_keep: assert property (
    setArr[EV_PEND] != '0
    |=> (evtArr[EV_PEND] & $past(setArr[EV_PEND] & PORT_MASK)) ==
        $past(setArr[EV_PEND] & PORT_MASK))
    else $error("pending event lost");

  a_sum_irq: assert property (
    $rose(sumFlag[EV_PEND]) |=> st_ff.irqSt[EV_PEND] ##0
    (irq == |(st_ff.irqSt & st_ff.irqMask)))
    else $error("summary did not reach interrupt status");

  a_flow_keep: assert property (
    xferDone && !pwrite && evtHit[EV_FLOW]
    |=> evtArr[EV_CTS] == ($past(evtArr[EV_CTS]) | ($past(setArr[EV_CTS]) & PORT_MASK)))
    else $error("flow read disturbed clear-to-send events");

  a_flow_en_bit: assert property (
    xferDone && pwrite && enHit[EV_FLOW] && selOk
    |=> st_ff.en[EV_FLOW][$past(st_ff.selPort)] == $past(pwdata[0]))
    else $error("flow enable bit write lost");

  a_cts_evt_set: assert property (
    ctsChange != '0
    |=> (evtArr[EV_CTS] & $past(ctsChange)) == $past(ctsChange))
    else $error("clear-to-send change not latched");

  a_cts_rdclr: assert property (
    xferDone && !pwrite && evtHit[EV_CTS]
    |=> (evtArr[EV_CTS] & $past(st_ff.clrBits) & ~$past(setArr[EV_CTS])) == '0)
    else $error("clear-to-send bits not cleared by read");

  a_cts_en_word: assert property (
    xferDone && pwrite && enHit[EV_CTS] && !st_ff.selValid
    |=> st_ff.en[EV_CTS] == ($past(pwdata[PW-1:0]) & PORT_MASK))
    else $error("clear-to-send enable word write lost");

  a_pend_rdclr: assert property (
    xferDone && !pwrite && evtHit[EV_PEND]
    |=> (evtArr[EV_PEND] & $past(st_ff.clrBits) & ~$past(setArr[EV_PEND])) == '0)
    else $error("pending bits not cleared by read");

  a_pend_en_word: assert property (
    xferDone && pwrite && enHit[EV_PEND] && !st_ff.selValid
    |=> st_ff.en[EV_PEND] == ($past(pwdata[PW-1:0]) & PORT_MASK))
    else $error("pending enable word write lost");

  a_sel_range: assert property (
    accPhase && !st_ff.ready && !pwrite && st_ff.selValid && !selOk && enHit[EV_TMO]
    |=> prdata[PW-1:0] == $past(st_ff.en[EV_TMO]))
    else $error("out of range selector not full word");

  a_sel_ignore: assert property (
    xferDone && pwrite && st_ff.selValid && !selOk && (enHit != '0)
    |=> st_ff.en == $past(st_ff.en))
    else $error("out of range selected write took effect");

endmodule : pss_port_status

// ---- core/pss_pkg.sv ----
package pss_pkg;

  localparam int          PW          = 14;
  localparam int          NEV         = 5;
  localparam int          DW          = 32;
  localparam int          AW          = 8;

  // Event register slots
  localparam int          EV_TMO      = 0;
  localparam int          EV_OVF      = 1;
  localparam int          EV_FLOW     = 2;
  localparam int          EV_CTS      = 3;
  localparam int          EV_PEND     = 4;

  // Port bits 1..9 module ports, 10..13 serial ports; bit 0 unused
  localparam logic [PW-1:0] PORT_MASK = 14'h3FFE;
  localparam logic [PW-1:0] CTS_PULL  = 14'h3C00;
  localparam logic [PW-1:0] PORT_ONE  = 14'h0001;
  localparam logic [3:0]  MIN_PORT    = 4'h1;
  localparam logic [3:0]  MAX_PORT    = 4'hD;
  localparam int          SUM_BIT     = 15;
  localparam int          SEL_VALID_BIT = 4;
  localparam int          SEL_PORT_W  = 4;

  // Register byte addresses
  localparam logic [AW-1:0] A_TMO_EVT  = 8'h00;
  localparam logic [AW-1:0] A_TMO_EN   = 8'h04;
  localparam logic [AW-1:0] A_OVF_EVT  = 8'h08;
  localparam logic [AW-1:0] A_OVF_EN   = 8'h0C;
  localparam logic [AW-1:0] A_FLOW_EVT = 8'h10;
  localparam logic [AW-1:0] A_FLOW_EN  = 8'h14;
  localparam logic [AW-1:0] A_CTS_EVT  = 8'h18;
  localparam logic [AW-1:0] A_CTS_EN   = 8'h1C;
  localparam logic [AW-1:0] A_PEND_EVT = 8'h20;
  localparam logic [AW-1:0] A_PEND_EN  = 8'h24;
  localparam logic [AW-1:0] A_CTS_LVL  = 8'h28;
  localparam logic [AW-1:0] A_PORT_SEL = 8'h2C;
  localparam logic [AW-1:0] A_IRQ_ST   = 8'h30;
  localparam logic [AW-1:0] A_IRQ_MASK = 8'h34;

  typedef struct packed {
    logic [NEV-1:0][PW-1:0] en;
    logic                   selValid;
    logic [SEL_PORT_W-1:0]  selPort;
    logic [NEV-1:0]         irqSt;
    logic [NEV-1:0]         irqMask;
    logic [NEV-1:0]         sumPrev;
    logic [PW-1:0]          ctsPrev;
    logic [NEV-1:0]         clrSel;
    logic [PW-1:0]          clrBits;
    logic [DW-1:0]          rdata;
    logic                   ready;
    logic                   slverr;
    logic                   irq;
  } pss_state_t;

  typedef struct packed {
    logic [PW-1:0] stage1;
    logic [PW-1:0] stage2;
  } pss_sync_t;

  typedef struct packed {
    logic [PW-1:0] evt;
  } pss_evt_t;

endpackage : pss_pkg

// ---- core/pss_sync.sv ----
`timescale 1ns/1ns
module pss_sync
  import pss_pkg::*;
#(
  parameter logic [PW-1:0] RST_VAL = CTS_PULL
)
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [PW-1:0] din,
  output logic      [PW-1:0] dout
);

  pss_sync_t st_ff;
  pss_sync_t nxt_st;

  always_comb
  begin
    nxt_st        = st_ff;
    nxt_st.stage1 = din;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= {RST_VAL, RST_VAL};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.stage2;

endmodule : pss_sync

// ---- core/pss_evt_reg.sv ----
`timescale 1ns/1ns
module pss_evt_reg
  import pss_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [PW-1:0] setBits,
  input  wire logic [PW-1:0] clrBits,
  output logic      [PW-1:0] evtBits
);

  pss_evt_t st_ff;
  pss_evt_t nxt_st;

  // Set applied after clear so a new event survives the clearing read
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.evt = ((st_ff.evt & ~clrBits) | setBits) & PORT_MASK;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign evtBits = st_ff.evt;

endmodule : pss_evt_reg

// ---- bench/pss_line_model.sv ----
`timescale 1ns/1ns
module pss_line_model
  import pss_pkg::*;
(
  input  wire logic [PW-1:0] modAttached,
  input  wire logic [PW-1:0] flowHold,
  output logic      [PW-1:0] ctsPin,
  output logic      [PW-1:0] ctsPinDriven
);
  // Attached module drives high, held serial line low
  assign ctsPinDriven = (modAttached & ~CTS_PULL) | (flowHold & CTS_PULL);
  // Undriven lines show the opposite of their pull
  assign ctsPin       = ~CTS_PULL;
endmodule : pss_line_model

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
module testbench
  import pss_pkg::*;
;
  logic          clk     = 1'b0;
  logic          rst_n   = 1'b0;
  logic          psel    = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite  = 1'b0;
  logic [AW-1:0] paddr   = '0;
  logic [DW-1:0] pwdata  = '0;
  logic [DW-1:0] prdata;
  logic [DW-1:0] rd;
  logic          pready;
  logic          pslverr;
  logic          errFlag;
  logic          irq;
  logic          irqA;
  logic [PW-1:0] evIn [4] = '{default: '0};
  logic [PW-1:0] attach  = '0;
  logic [PW-1:0] hold    = '0;
  logic [PW-1:0] ctsPin;
  logic [PW-1:0] ctsDrv;
  int            numErrors = 0;
  int            nChecks   = 0;
  int            cycles    = 0;
  localparam logic [AW-1:0] EVA [4] = '{A_TMO_EVT, A_OVF_EVT, A_FLOW_EVT, A_PEND_EVT};
  localparam logic [AW-1:0] ENA [5] = '{A_TMO_EN, A_OVF_EN, A_FLOW_EN, A_CTS_EN, A_PEND_EN};

  initial forever #25 clk = ~clk;

  pss_port_status i_pss_port_status (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timeoutEvt(evIn[0]), .overflowEvt(evIn[1]),
    .flowEvt(evIn[2]), .pendingEvt(evIn[3]), .ctsPin(ctsPin),
    .ctsPinDriven(ctsDrv), .irq(irq));

  pss_line_model i_pss_line_model (
    .modAttached(attach), .flowHold(hold), .ctsPin(ctsPin), .ctsPinDriven(ctsDrv));

  task automatic wrapUp();
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrapUp

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      numErrors++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    errFlag = pslverr;
    if (n >= 20)
    begin
      $display("[ERR] %0t pready %h exp %h", $time, pready, 1'b1);
      numErrors++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input int k, input logic [PW-1:0] b);
    @(posedge clk);
    evIn[k] <= b;
    @(posedge clk);
    evIn[k] <= '0;
  endtask : pulse

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      numErrors++;
      wrapUp();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, A_CTS_LVL, '0);
    chk(rd, 32'h00003C00);
    attach <= 14'h0010;
    hold <= 14'h0800;
    repeat (6) @(posedge clk);
    apb(1'b0, A_CTS_LVL, '0);
    chk(rd, 32'h00003410);
    apb(1'b0, A_CTS_EVT, '0);
    chk(rd, 32'h00000810);
    apb(1'b0, A_CTS_EVT, '0);
    chk(rd, '0);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, ENA[i], 32'hFFFFFFFF);
      apb(1'b0, ENA[i], '0);
      chk(rd, DW'(PORT_MASK));
    end
    apb(1'b1, A_PORT_SEL, 32'h00000015);
    apb(1'b0, A_PORT_SEL, '0);
    chk(rd, 32'h00000015);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, ENA[i], '0);
      apb(1'b0, ENA[i], '0);
      chk(rd, '0);
    end
    apb(1'b1, A_PORT_SEL, '0);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ENA[i], '0);
      chk(rd, 32'h00003FDE);
    end
    for (int k = 0; k < 4; k++)
    begin
      pulse(k, 14'h2007);
      apb(1'b0, EVA[k], '0);
      chk(rd, 32'h00002006);
      apb(1'b0, EVA[k], '0);
      chk(rd, '0);
    end
    pulse(3, 14'h0060);
    apb(1'b1, A_PORT_SEL, 32'h00000015);
    apb(1'b0, A_PEND_EVT, '0);
    chk(rd, 32'h00000001);
    apb(1'b1, A_PORT_SEL, '0);
    apb(1'b0, A_PEND_EVT, '0);
    chk(rd, 32'h00000040);
    pulse(0, 14'h0004);
    fork
      apb(1'b0, A_TMO_EVT, '0);
      begin
        repeat (3) @(posedge clk);
        evIn[0] <= 14'h0200;
        @(posedge clk);
        evIn[0] <= '0;
      end
    join
    chk(rd, 32'h00000004);
    apb(1'b0, A_TMO_EVT, '0);
    chk(rd, 32'h00000200);
    apb(1'b1, A_IRQ_ST, 32'h0000001F);
    apb(1'b1, A_IRQ_MASK, '0);
    pulse(1, 14'h0008);
    repeat (2) @(posedge clk);
    apb(1'b0, A_IRQ_ST, '0);
    chk(rd, 32'h00000002);
    irqA = irq;
    apb(1'b1, A_IRQ_MASK, 32'h0000001F);
    repeat (2) @(posedge clk);
    chk(DW'(irqA), '0);
    chk(DW'(irq), 32'h00000001);
    apb(1'b0, A_IRQ_MASK, '0);
    chk(rd, 32'h0000001F);
    apb(1'b1, A_IRQ_ST, 32'h00000002);
    apb(1'b0, A_IRQ_ST, '0);
    chk(rd, '0);
    chk(DW'(irq), '0);
    attach <= '0;
    repeat (6) @(posedge clk);
    apb(1'b0, A_FLOW_EVT, '0);
    chk(rd, 32'h00008000);
    apb(1'b0, A_FLOW_EVT, '0);
    chk(rd, 32'h00008000);
    apb(1'b0, 8'h38, '0);
    chk(DW'(errFlag), 32'h00000001);
    chk(rd, '0);
    apb(1'b1, A_OVF_EVT, 32'h00003FFE);
    apb(1'b0, A_OVF_EVT, '0);
    chk(rd, 32'h00000008);
    apb(1'b1, A_PORT_SEL, 32'h0000001C);
    apb(1'b0, A_CTS_LVL, '0);
    chk(rd, 32'h00000001);
    apb(1'b1, A_PORT_SEL, 32'h00000010);
    apb(1'b1, A_TMO_EN, '0);
    apb(1'b0, A_TMO_EN, '0);
    chk(rd, 32'h00003FDE);
    apb(1'b1, A_PORT_SEL, '0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, A_TMO_EN, '0);
    chk(rd, '0);
    apb(1'b0, A_IRQ_MASK, '0);
    chk(rd, '0);
    apb(1'b0, A_CTS_LVL, '0);
    chk(rd, 32'h00003400);
    apb(1'b0, A_CTS_EVT, '0);
    chk(rd, 32'h00000800);
    wrapUp();
  end
endmodule : testbench
